// [hdl/sr_receiver.sv]
// Asynchronous serial receiver with AXI4-Lite register slave.
// Assumes a remote transmitter on rx_pin and one aclk domain.
`timescale 1ns/1ps
`include "sr_map.svh"
module sr_receiver #(
  parameter int DIV_W = 12
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`SR_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`SR_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   rx_pin,
  input  wire logic                   dma_rd_strobe,
  output logic [7:0]                  dma_rd_data,
  output logic                        rx_irq_req,
  output logic                        rx_dma_req
);
  initial begin
    if (DIV_W < 2 || DIV_W > 16) begin
      $error("sr_receiver: DIV_W out of range");
    end
  end

  // ----------------------------------------
  // Majority and disagreement helpers
  // ----------------------------------------
  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic split3(input logic [2:0] s);
    split3 = ~((&s) | ~(|s));
  endfunction

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [7:0]       ctrl_one_q;
  logic [7:0]       ctrl_two_q;
  logic [7:0]       ctrl_three_q;
  logic [7:0]       baud_q;
  wire              len9_w  = ctrl_one_q[`SR_BIT_LEN];
  wire              rxie_w  = ctrl_two_q[`SR_BIT_RXIE];
  wire              rxen_w  = ctrl_two_q[`SR_BIT_RXEN];
  wire              dmaen_w = ctrl_three_q[`SR_BIT_DMA];
  wire [DIV_W-1:0]  divisor_w;
  logic             tick;
  logic             rx_s;

  // Baud field: prescale bits 5:4, rate bits 2:0
  assign divisor_w = DIV_W'({baud_q[5:4], baud_q[2:0]});

  sr_tick_gen #(.DIV_W(DIV_W)) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .divisor (divisor_w),
    .tick    (tick)
  );

  sr_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (rx_pin),
    .dout    (rx_s)
  );

  // ----------------------------------------
  // Receive state machine
  // ----------------------------------------
  sr_pkg::sr_state_e state_q;
  logic [4:0]        rt_q;
  logic [2:0]        hist_q;
  logic [2:0]        samp_q;
  logic [3:0]        bitn_q;
  logic [8:0]        shift_q;
  logic              noise_q;
  logic              prev_bit_q;
  logic              done_q;
  sr_pkg::sr_char_s  char_q;

  wire        search_fall_w = rxen_w & (hist_q == 3'b111) & ~rx_s;
  wire [4:0]  rt_next_w     = rt_q + 5'd1;
  wire        at_a_w        = (rt_q == `SR_TICK_START_A) || (rt_q == `SR_TICK_VOTE_A);
  wire        at_b_w        = (rt_q == `SR_TICK_START_B) || (rt_q == `SR_TICK_VOTE_B);
  wire        at_c_w        = (rt_q == `SR_TICK_START_C);
  wire        at_vote_w     = (rt_q == `SR_TICK_VOTE_C);
  wire [2:0]  start_s_w     = {samp_q[2], samp_q[1], rx_s};
  wire [2:0]  vote_s_w      = {samp_q[2], samp_q[1], rx_s};
  wire        vbit_w        = vote3(vote_s_w);
  wire [3:0]  nbits_w       = len9_w ? 4'd9 : 4'd8;
  wire        last_w        = (rt_q == (`SR_TICKS_PER_BIT - 5'd1));
  // Resync on a voted one-to-zero change inside the character
  wire        fall_in_w     = tick & (state_q == sr_pkg::SR_DATA) & prev_bit_q & ~rx_s
                              & (rt_q > `SR_TICK_VOTE_C);
  wire [8:0]  full_w        = {rx_s, shift_q[8:1]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= sr_pkg::SR_IDLE;
      rt_q       <= '0;
      hist_q     <= '0;
      samp_q     <= '0;
      bitn_q     <= '0;
      shift_q    <= '0;
      noise_q    <= 1'b0;
      prev_bit_q <= 1'b1;
      done_q     <= 1'b0;
      char_q     <= '0;
    end else begin
      done_q <= 1'b0;
      if (tick) begin
        // see [RULE_06]
        hist_q <= {hist_q[1:0], rx_s};
        rt_q   <= rt_next_w;
        if (at_a_w) begin
          samp_q[2] <= rx_s;
        end
        if (at_b_w) begin
          samp_q[1] <= rx_s;
        end
        case (state_q)
          sr_pkg::SR_IDLE: begin
            rt_q <= '0;
            if (search_fall_w) begin
              // see [RULE_08] [RULE_21]
              state_q <= sr_pkg::SR_START;
              rt_q    <= 5'd1;
              noise_q <= 1'b0;
            end
          end
          sr_pkg::SR_START: begin
            if (at_c_w) begin
              if (vote3(start_s_w)) begin
                // see [RULE_10]
                state_q <= sr_pkg::SR_IDLE;
                rt_q    <= '0;
                hist_q  <= '0;
              end else if (split3(start_s_w)) begin
                noise_q <= 1'b1; // see [RULE_09]
              end
            end
            if (at_vote_w && (|vote_s_w)) begin
              noise_q <= 1'b1; // see [RULE_12]
            end
            if (last_w) begin
              // see [RULE_07]
              state_q    <= sr_pkg::SR_DATA;
              rt_q       <= '0;
              bitn_q     <= '0;
              prev_bit_q <= 1'b0;
            end
          end
          sr_pkg::SR_DATA: begin
            if (at_vote_w) begin
              // see [RULE_11]
              shift_q    <= {vbit_w, shift_q[8:1]};
              prev_bit_q <= vbit_w;
              if (split3(vote_s_w)) begin
                noise_q <= 1'b1;
              end
            end
            if (fall_in_w) begin
              // see [RULE_07] [RULE_16]
              rt_q       <= 5'd1;
              bitn_q     <= bitn_q + 4'd1;
              prev_bit_q <= 1'b0;
              if (bitn_q + 4'd1 == nbits_w) begin
                state_q <= sr_pkg::SR_STOP;
              end
            end else if (last_w) begin
              rt_q   <= '0;
              bitn_q <= bitn_q + 4'd1;
              if (bitn_q + 4'd1 == nbits_w) begin
                state_q <= sr_pkg::SR_STOP;
              end
            end
          end
          sr_pkg::SR_STOP: begin
            if (at_vote_w) begin
              // see [RULE_13] [RULE_14] [RULE_01]
              state_q         <= sr_pkg::SR_IDLE;
              rt_q            <= '0;
              hist_q          <= '0;
              done_q          <= 1'b1;
              char_q.frame_err <= ~vbit_w;
              char_q.noise    <= noise_q | split3(vote_s_w);
              char_q.brk      <= ~vbit_w & ~(|(len9_w ? shift_q : {1'b0, shift_q[8:1]}));
              if (len9_w) begin
                char_q.data  <= shift_q[7:0];
                char_q.ninth <= shift_q[8];
              end else begin
                char_q.data  <= shift_q[8:1];
                char_q.ninth <= shift_q[8]; // see [RULE_02]
              end
            end
          end
          default: begin
            state_q <= sr_pkg::SR_IDLE;
          end
        endcase
        if (!rxen_w) begin
          state_q <= sr_pkg::SR_IDLE;
        end
      end
    end
  end

  // ----------------------------------------
  // Status flags and data buffer
  // ----------------------------------------
  logic [7:0] data_q;
  logic       ninth_q;
  logic       full_q;
  logic       noise_f_q;
  logic       fe_q;
  logic       ovr_q;
  logic       brk_q;
  logic       armed_q;

  // Register index is the byte address divided by four
  wire rd_data_w   = s_axi_arvalid & s_axi_arready & (s_axi_araddr == {`SR_OFF_DATA, 2'b00});
  wire rd_stat1_w  = s_axi_arvalid & s_axi_arready
                     & (s_axi_araddr == {`SR_OFF_STATUS_ONE, 2'b00});
  wire dma_mode_w  = rxie_w & dmaen_w;
  // see [RULE_20]
  wire clr_full_w  = (rd_data_w & armed_q) | (dma_rd_strobe & dma_mode_w);
  wire clr_err_w   = rd_data_w & armed_q;
  wire accept_w    = done_q & ~full_q;
  wire overrun_w   = done_q & full_q;

  assign dma_rd_data = data_q; // see [RULE_17]
  // see [RULE_04] [RULE_05]
  assign rx_irq_req  = full_q & rxie_w & ~dmaen_w;
  assign rx_dma_req  = full_q & rxie_w & dmaen_w;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q    <= '0;
      ninth_q   <= 1'b0;
      full_q    <= 1'b0;
      noise_f_q <= 1'b0;
      fe_q      <= 1'b0;
      ovr_q     <= 1'b0;
      brk_q     <= 1'b0;
      armed_q   <= 1'b0;
    end else begin
      if (rd_stat1_w) begin
        armed_q <= 1'b1;
      end else if (rd_data_w) begin
        armed_q <= 1'b0;
      end
      if (clr_full_w) begin
        full_q <= 1'b0;
      end
      if (clr_err_w) begin
        noise_f_q <= 1'b0;
        fe_q      <= 1'b0;
        ovr_q     <= 1'b0;
        brk_q     <= 1'b0;
      end
      // Set wins over clear
      if (accept_w) begin
        // see [RULE_03] [RULE_15] [RULE_18]
        full_q    <= 1'b1;
        data_q    <= char_q.brk ? 8'h00 : char_q.data;
        ninth_q   <= char_q.brk ? 1'b0 : char_q.ninth;
        fe_q      <= char_q.frame_err | fe_q & ~clr_err_w;
        noise_f_q <= char_q.noise | noise_f_q & ~clr_err_w;
        brk_q     <= char_q.brk | brk_q & ~clr_err_w;
      end
      if (overrun_w) begin
        ovr_q <= 1'b1; // see [RULE_19]
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic        aw_q;
  logic        w_q;
  logic [7:0]  awaddr_q;
  logic [7:0]  wdata_q;
  logic        wstrb0_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  wire       do_wr_w   = aw_q & w_q & ~bvalid_q;
  wire [7:0] rd_addr_w = s_axi_araddr[9:2];
  wire       rd_hit_w  = (s_axi_araddr[1:0] == 2'b00) && (rd_addr_w >= `SR_OFF_CTRL_ONE)
                         && (rd_addr_w <= `SR_OFF_BAUD);
  wire       wr_hit_w  = (awaddr_q == `SR_OFF_CTRL_ONE) || (awaddr_q == `SR_OFF_CTRL_TWO)
                         || (awaddr_q == `SR_OFF_CTRL_THREE) || (awaddr_q == `SR_OFF_BAUD)
                         || (awaddr_q == `SR_OFF_STATUS_ONE) || (awaddr_q == `SR_OFF_STATUS_TWO)
                         || (awaddr_q == `SR_OFF_DATA);
  logic [7:0] rd_mux_w;

  always_comb begin
    case (rd_addr_w)
      `SR_OFF_CTRL_ONE:   rd_mux_w = ctrl_one_q;
      `SR_OFF_CTRL_TWO:   rd_mux_w = ctrl_two_q;
      `SR_OFF_CTRL_THREE: rd_mux_w = {ninth_q, 1'b0, ctrl_three_q[5], 5'b0_0000};
      `SR_OFF_STATUS_ONE: rd_mux_w = {2'b00, full_q, 1'b0, ovr_q, noise_f_q, fe_q, 1'b0};
      `SR_OFF_STATUS_TWO: rd_mux_w = {6'b00_0000, brk_q, 1'b0};
      `SR_OFF_DATA:       rd_mux_w = data_q;
      `SR_OFF_BAUD:       rd_mux_w = baud_q;
      default:            rd_mux_w = 8'h00;
    endcase
  end

  assign s_axi_awready = ~aw_q;
  assign s_axi_wready  = ~w_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q         <= 1'b0;
      w_q          <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      wstrb0_q     <= 1'b0;
      bvalid_q     <= 1'b0;
      bresp_q      <= `SR_AXI_OKAY;
      rvalid_q     <= 1'b0;
      rdata_q      <= '0;
      rresp_q      <= `SR_AXI_OKAY;
      ctrl_one_q   <= `SR_RST_BYTE;
      ctrl_two_q   <= `SR_RST_BYTE;
      ctrl_three_q <= `SR_RST_BYTE;
      baud_q       <= `SR_RST_BYTE;
    end else begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q     <= 1'b1;
        awaddr_q <= (s_axi_awaddr[1:0] == 2'b00) ? s_axi_awaddr[9:2] : 8'hFF;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q      <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_wr_w) begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit_w ? `SR_AXI_OKAY : `SR_AXI_SLVERR;
        if (wstrb0_q) begin
          case (awaddr_q)
            `SR_OFF_CTRL_ONE:   ctrl_one_q   <= wdata_q & `SR_CTRL_ONE_MASK;
            `SR_OFF_CTRL_TWO:   ctrl_two_q   <= wdata_q & `SR_CTRL_TWO_MASK;
            `SR_OFF_CTRL_THREE: ctrl_three_q <= wdata_q & `SR_CTRL_THREE_MASK;
            `SR_OFF_BAUD:       baud_q       <= wdata_q & `SR_BAUD_MASK;
            default:            ctrl_one_q   <= ctrl_one_q;
          endcase
        end
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (s_axi_arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rdata_q  <= {24'h00_0000, rd_mux_w};
        rresp_q  <= rd_hit_w ? `SR_AXI_OKAY : `SR_AXI_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
endmodule

// [hdl/sr_sync.sv]
// Two-flop synchroniser for the receive pin.
// Assumes the input is asynchronous to aclk; idles high.
`timescale 1ns/1ps
module sr_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  logic sync_q;

  assign dout = sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end
endmodule

// [hdl/sr_tick_gen.sv]
// Sampling tick divider at sixteen times the baud rate.
// Assumes divisor is set by software; one-cycle tick output.
`timescale 1ns/1ps
module sr_tick_gen #(
  parameter int DIV_W = 12
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);
  initial begin
    if (DIV_W < 2 || DIV_W > 16) begin
      $error("sr_tick_gen: DIV_W out of range");
    end
  end

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  wire              wrap_w = (cnt_q >= divisor);

  assign cnt_d = wrap_w ? '0 : cnt_q + 1'b1;
  assign tick  = wrap_w;

  // see [RULE_21]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// [pkg/sr_map.svh]
// Register offsets, field positions, reset values and timing counts for the serial receiver.
// Assumes inclusion by bare name from the receiver, assertion and bench modules.
//
// Function
// [RULE_01] Character length is 8 or 9 data bits, chosen by control one length bit.
// [RULE_02] Ninth-bit field holds bit 8 in 9-bit mode, copy of bit 7 otherwise.
// [RULE_03] Completed character moves into data register and sets receive-full flag.
// [RULE_04] Receive interrupt enable lets receive-full raise a CPU or DMA request.
// [RULE_05] DMA enable routes receive-full to DMA request and suppresses CPU request.
// [RULE_06] Receive pin is sampled on a tick at sixteen times the baud rate.
// [RULE_07] Tick counter resyncs after start bit and on voted one-to-zero data change.
// [RULE_08] Start search needs a zero after three ones; counting starts at that edge.
// [RULE_09] Start samples at ticks 3,5,7; two zeros verify; disagreement flags noise.
// [RULE_10] Failed start verification resets tick counter and restarts search.
// [RULE_11] Data bit is majority of ticks 8,9,10; disagreement sets noise flag.
// [RULE_12] Ones at ticks 8 to 10 of verified start set noise, start still kept.
// [RULE_13] Stop bit voted at ticks 8,9,10; majority zero framing error; disagreement noise.
// [RULE_14] Missing stop bit sets framing error, including on a break character.
// [RULE_15] Framing error rises in the same cycle as receive-full.
// [RULE_16] Tick counter resyncs on every valid falling edge inside a character.
// [RULE_17] Data register is a read-only holding buffer toward the bus.
// [RULE_18] Break sets full and framing error, clears data and ninth bit, sets break flag.
// [RULE_19] Character completing while full sets overrun, keeps old data, drops new one.
// [RULE_20] Full clears after status-one read then data read, or by DMA data read alone.
// [RULE_21] Tick comes from a configurable baud divider; search only while receiver enabled.
`ifndef SR_MAP_SVH
`define SR_MAP_SVH
`define SR_OFF_CTRL_ONE    8'h13
`define SR_OFF_CTRL_TWO    8'h14
`define SR_OFF_CTRL_THREE  8'h15
`define SR_OFF_STATUS_ONE  8'h16
`define SR_OFF_STATUS_TWO  8'h17
`define SR_OFF_DATA        8'h18
`define SR_OFF_BAUD        8'h19
`define SR_ADDR_W          10
`define SR_CTRL_ONE_MASK   8'h10
`define SR_CTRL_TWO_MASK   8'h24
`define SR_CTRL_THREE_MASK 8'h20
`define SR_BAUD_MASK       8'h37
`define SR_RST_BYTE        8'h00
`define SR_BIT_LEN         4
`define SR_BIT_RXIE        5
`define SR_BIT_RXEN        2
`define SR_BIT_DMA         5
`define SR_TICKS_PER_BIT   5'd16
`define SR_TICK_START_A    5'd3
`define SR_TICK_START_B    5'd5
`define SR_TICK_START_C    5'd7
`define SR_TICK_VOTE_A     5'd8
`define SR_TICK_VOTE_B     5'd9
`define SR_TICK_VOTE_C     5'd10
`define SR_AXI_OKAY        2'b00
`define SR_AXI_SLVERR      2'b10
`endif

// [pkg/sr_pkg.sv]
// Types for the serial receiver.
// Assumes sr_map.svh is on the include path.
package sr_pkg;
  typedef enum logic [1:0] {
    SR_IDLE  = 2'b00,
    SR_START = 2'b01,
    SR_DATA  = 2'b10,
    SR_STOP  = 2'b11
  } sr_state_e;

  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
    logic       noise;
    logic       frame_err;
    logic       brk;
  } sr_char_s;
endpackage

// [verification/sr_receiver_assertions.sv]
// Concurrent checks on the serial receiver top ports.
// Assumes binding into sr_receiver; one aclk domain.
`timescale 1ns/1ps
`include "sr_map.svh"
module sr_receiver_assertions #(
  parameter int DIV_W = 12
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        dma_rd_strobe,
  input wire logic        rx_irq_req,
  input wire logic        rx_dma_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response not within two cycles");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read response not on next cycle");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_arready_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_rresp_code: assert property (s_axi_rvalid
    |-> s_axi_rresp == `SR_AXI_OKAY || s_axi_rresp == `SR_AXI_SLVERR)
    else $error("illegal read response code");
  a_req_exclusive: assert property (!(rx_irq_req && rx_dma_req))
    else $error("cpu and dma request together");
  a_dma_clear: assert property (rx_dma_req && dma_rd_strobe |=> !rx_dma_req)
    else $error("dma read did not clear request");
endmodule

bind sr_receiver sr_receiver_assertions #(.DIV_W(DIV_W)) chk_u (.*);

// [verification/sr_receiver_tb_top.sv]
// Self-checking bench for the serial receiver over AXI4-Lite.
// Assumes sr_tx_model on rx_pin; baud select 8'h01 gives 32 cycles a bit.
`timescale 1ns/1ps
`include "sr_map.svh"
module sr_receiver_tb_top;
  logic                  aclk = 1'b0;
  logic                  aresetn = 1'b0;
  logic [`SR_ADDR_W-1:0] s_axi_awaddr = '0;
  logic                  s_axi_awvalid = 1'b0;
  logic                  s_axi_awready;
  logic [31:0]           s_axi_wdata = '0;
  logic [3:0]            s_axi_wstrb = '0;
  logic                  s_axi_wvalid = 1'b0;
  logic                  s_axi_wready;
  logic [1:0]            s_axi_bresp;
  logic                  s_axi_bvalid;
  logic                  s_axi_bready = 1'b0;
  logic [`SR_ADDR_W-1:0] s_axi_araddr = '0;
  logic                  s_axi_arvalid = 1'b0;
  logic                  s_axi_arready;
  logic [31:0]           s_axi_rdata;
  logic [1:0]            s_axi_rresp;
  logic                  s_axi_rvalid;
  logic                  s_axi_rready = 1'b0;
  logic                  rx_pin;
  logic                  dma_rd_strobe = 1'b0;
  logic [7:0]            dma_rd_data;
  logic                  rx_irq_req;
  logic                  rx_dma_req;
  int                    err_total = 0;
  int                    n_compared = 0;

  always #25 aclk = ~aclk;
  sr_receiver dut_u (.*);
  sr_tx_model #(.BIT_CYC(32)) tx_u (.aclk(aclk), .line(rx_pin));

  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic a, w;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    a = 1'b1;
    w = 1'b1;
    while (a || w) begin
      @(negedge aclk);
      a = a && !s_axi_awready;
      w = w && !s_axi_wready;
      @(posedge aclk);
      if (!a) s_axi_awvalid <= 1'b0;
      if (!w) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    chk("bresp", 32'(`SR_AXI_OKAY), 32'(s_axi_bresp));
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic a;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    a = 1'b1;
    while (a) begin
      @(negedge aclk);
      a = !s_axi_arready;
      @(posedge aclk);
      if (!a) s_axi_arvalid <= 1'b0;
    end
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    chk(nm, {24'h00_0000, e}, d);
    chk("rresp", 32'(`SR_AXI_OKAY), 32'(r));
  endtask
  // Send one frame, then check flags, data, ninth bit and the clear sequence
  task automatic chr(input logic [8:0] tx, input int nb, input logic stop, input int gl,
                     input logic [7:0] st, input logic [7:0] dat, input logic nin,
                     input logic brk);
    tx_u.send(tx, nb, stop, gl);
    @(negedge aclk);
    chk("rx_irq_req", 32'(st[5]), 32'(rx_irq_req));
    rchk(`SR_OFF_STATUS_TWO, {6'h00, brk, 1'b0}, "status_two");
    rchk(`SR_OFF_STATUS_ONE, st, "status_one");
    rchk(`SR_OFF_DATA, dat, "data_buffer");
    rchk(`SR_OFF_CTRL_THREE, {nin, 7'h00}, "ninth_bit");
    rchk(`SR_OFF_STATUS_ONE, 8'h00, "status_one");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    report_and_stop();
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`SR_OFF_STATUS_ONE, 8'h00, "status_one");
    rchk(`SR_OFF_CTRL_TWO, 8'h00, "ctrl_two");
    rd(8'h3F, d, r);
    chk("unmapped rresp", 32'(`SR_AXI_SLVERR), 32'(r));
    wr(`SR_OFF_BAUD, 8'h01);
    wr(`SR_OFF_CTRL_TWO, 8'h24);
    rchk(`SR_OFF_CTRL_TWO, 8'h24, "ctrl_two");
    $display("done registers");
    chr(9'h0A5, 8, 1'b1, -1, 8'h20, 8'hA5, 1'b1, 1'b0);
    wr(`SR_OFF_CTRL_ONE, 8'h10);
    chr(9'h13C, 9, 1'b1, -1, 8'h20, 8'h3C, 1'b1, 1'b0);
    wr(`SR_OFF_CTRL_ONE, 8'h00);
    $display("done lengths");
    chr(9'h055, 8, 1'b0, -1, 8'h22, 8'h55, 1'b0, 1'b0);
    chr(9'h000, 8, 1'b0, -1, 8'h22, 8'h00, 1'b0, 1'b1);
    chr(9'h0F0, 8, 1'b1, 3, 8'h24, 8'hF0, 1'b1, 1'b0);
    tx_u.runt();
    chr(9'h05A, 8, 1'b1, -1, 8'h20, 8'h5A, 1'b0, 1'b0);
    tx_u.send(9'h011, 8, 1'b1, -1);
    chr(9'h022, 8, 1'b1, -1, 8'h28, 8'h11, 1'b0, 1'b0);
    $display("done errors");
    wr(`SR_OFF_CTRL_THREE, 8'h20);
    tx_u.send(9'h0C3, 8, 1'b1, -1);
    @(negedge aclk);
    chk("rx_dma_req", 32'h0000_0001, 32'(rx_dma_req));
    chk("rx_irq_req", 32'h0000_0000, 32'(rx_irq_req));
    chk("dma_rd_data", 32'h0000_00C3, 32'(dma_rd_data));
    @(posedge aclk);
    dma_rd_strobe <= 1'b1;
    @(posedge aclk);
    dma_rd_strobe <= 1'b0;
    @(negedge aclk);
    chk("rx_dma_req", 32'h0000_0000, 32'(rx_dma_req));
    rchk(`SR_OFF_STATUS_ONE, 8'h00, "status_one");
    wr(`SR_OFF_CTRL_THREE, 8'h00);
    wr(`SR_OFF_CTRL_TWO, 8'h20);
    tx_u.send(9'h066, 8, 1'b1, -1);
    rchk(`SR_OFF_STATUS_ONE, 8'h00, "status_one");
    $display("done dma and enable");
    report_and_stop();
  end
endmodule

// [verification/sr_tx_model.sv]
// Remote serial transmitter driving the receive line.
// Assumes aclk paces bit times; line idles high between frames.
`timescale 1ns/1ps
module sr_tx_model #(
  parameter int BIT_CYC = 32
) (
  input  wire logic aclk,
  output logic      line
);
  initial line = 1'b1;
  // Start, data lsb first, stop; bit gl gets a two-cycle glitch
  task automatic send(input logic [8:0] d, input int nb, input logic stop, input int gl);
    logic v;
    for (int i = 0; i <= nb + 1; i++) begin
      v = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : stop;
      for (int c = 0; c < BIT_CYC; c++) begin
        @(posedge aclk);
        line <= (i == gl && (c == 17 || c == 18)) ? ~v : v;
      end
    end
    @(posedge aclk);
    line <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge aclk);
  endtask
  // Short low pulse that must fail start verification
  task automatic runt();
    @(posedge aclk);
    line <= 1'b0;
    repeat (4) @(posedge aclk);
    line <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge aclk);
  endtask
endmodule
